// File: common/icc_defs.svh
// Purpose: Constants for the input capture channel block.
// Assumes: Included by bare name; definitions only.
// Notes: Mode codes follow the three-bit capture mode selector.
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH
`define ICC_NUM_CH 8
`define ICC_DATA_W 16
`define ICC_DEPTH 4
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_EVERY 3'h1
`define ICC_MODE_FALL 3'h2
`define ICC_MODE_RISE 3'h3
`define ICC_MODE_PRE4 3'h4
`define ICC_MODE_PRE16 3'h5
`define ICC_MODE_RSVD 3'h6
`define ICC_MODE_WAKE 3'h7
`define ICC_PRE4_LAST 4'h3
`define ICC_PRE16_LAST 4'hf
`define ICC_CTRL_RESET 7'h00
`define ICC_TB_RESET 1'b1
`endif

// File: common/icc_pkg.sv
// Purpose: Types shared by the input capture channel block.
// Assumes: Constants come from icc_defs.svh.
// Notes: One control word per channel.
`include "icc_defs.svh"
package icc_pkg;
	typedef struct packed {
		logic stop_in_idle_bit;
		logic timebase_select;
		logic [1:0] irq_event_count_sel;
		logic [2:0] capture_mode_sel;
	} icc_ctrl_t;
	typedef struct packed {
		logic buffer_not_empty_flag;
		logic capture_overflow_flag;
		logic capture_irq_flag;
		logic wake_req;
	} icc_stat_t;
endpackage

// File: logic/icc_capture.sv
// Purpose: Eight input capture channels with four-entry FIFOs, prescaler and flags.
// Assumes: sys_clk is the peripheral clock; timer counts are on that clock; pins are asynchronous.
// Notes: Control arrives as plain ports; buffer reads are one-cycle strobes per channel.
`timescale 1ns/1ps
`include "icc_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - Eight independent channels, each with mode, FIFO and flags.
// - Capture on falling, rising, or both edges by mode selector.
// - Prescaled modes capture every 4th or 16th rising edge.
// - Prescaler counter clears while the channel is off.
// - Any reset clears every prescaler counter.
// - Each channel has a four-entry, 16-bit FIFO.
// - Not-empty flag set on first capture, held until FIFO drained.
// - A read returns the oldest entry and advances the rest.
// - Capture into a full FIFO is discarded and sets overflow (no overflow in every-edge mode); with a read in the same cycle it is stored unless overflow is set.
// - After overflow, no capture stored until all four read.
// - Control bit 5 selects one of two 16-bit timers.
// - Timebase select resets to the second timer.
// - Every-edge mode flags interrupt on each edge, ignoring event count.
// - Every-edge mode never raises overflow.
// - Mode 111 with interrupt enabled wakes device from sleep or idle.
// - Capture wake-up also raises the interrupt flag, except in idle with stop-in-idle set.
// - In sleep the channel is only an interrupt source, count ignored.
// - Interrupt raised after 1 to 4 captures per bits 4:3.
module icc_capture #(
	parameter int NUM_CH = `ICC_NUM_CH,
	parameter int DATA_W = `ICC_DATA_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [NUM_CH-1:0] cap_pin,
	input wire logic [DATA_W-1:0] timer2_count,
	input wire logic [DATA_W-1:0] timer3_count,
	input wire logic cpu_sleep,
	input wire logic cpu_idle,
	input wire icc_pkg::icc_ctrl_t [NUM_CH-1:0] capture_control_reg,
	input wire logic [NUM_CH-1:0] ctrl_wr,
	input wire logic [NUM_CH-1:0] capture_irq_enable,
	input wire logic [NUM_CH-1:0] buf_rd,
	input wire logic [NUM_CH-1:0] irq_flag_clr,
	output logic [NUM_CH-1:0][DATA_W-1:0] buf_rdata,
	output icc_pkg::icc_stat_t [NUM_CH-1:0] chan_status,
	output logic wake_up
);
	import icc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Wake requests of all channels, gathered for the shared wake-up flop.
	logic [NUM_CH-1:0] wake_vec;

	////////////////////////////////////////////////////////////////////////////////
	// Every channel is an identical copy with its own state; none reads another.
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : ch
			// Control word as last written by software.
			icc_ctrl_t ctrl_r;

			// Pin synchroniser and the previous sample used for edge detection.
			logic sync1_r;
			logic sync2_r;
			logic prev_r;

			// Prescaler edge counter and interrupt event counter.
			logic [3:0] pre_cnt_r;
			logic [1:0] ev_cnt_r;

			// Capture storage, its fill level and the last popped word.
			logic [DATA_W-1:0] fifo_r [`ICC_DEPTH];
			logic [2:0] level_r;
			logic [DATA_W-1:0] rdata_r;

			// Status flags.
			logic ovf_r;
			logic bne_r;
			logic irq_r;
			logic wake_r;

			////////////////////////////////////////////////////////////////////////
			// Edge detection and mode decode.
			wire logic rise;
			wire logic fall;
			wire logic [2:0] mode;
			wire logic mode_off;
			wire logic mode_every;
			wire logic mode_fall;
			wire logic mode_rise;
			wire logic mode_pre4;
			wire logic mode_pre16;
			wire logic mode_wake;
			wire logic is_pre;
			wire logic [3:0] pre_last;
			wire logic pre_hit;
			wire logic event_awake;
			wire logic event_q;

			assign rise = sync2_r & ~prev_r;
			assign fall = ~sync2_r & prev_r;
			assign mode = ctrl_r.capture_mode_sel;
			assign mode_off = (mode == `ICC_MODE_OFF);
			assign mode_every = (mode == `ICC_MODE_EVERY);
			assign mode_fall = (mode == `ICC_MODE_FALL);
			assign mode_rise = (mode == `ICC_MODE_RISE);
			assign mode_pre4 = (mode == `ICC_MODE_PRE4);
			assign mode_pre16 = (mode == `ICC_MODE_PRE16);
			assign mode_wake = (mode == `ICC_MODE_WAKE);
			assign is_pre = mode_pre4 | mode_pre16;
			assign pre_last = mode_pre4 ? `ICC_PRE4_LAST : `ICC_PRE16_LAST;
			assign pre_hit = rise & (pre_cnt_r == pre_last);

			// The reserved mode code matches no term below, so it captures nothing.
			assign event_awake = (mode_every & (rise | fall)) |
				(mode_fall & fall) |
				(mode_rise & rise) |
				(is_pre & pre_hit) |
				(mode_wake & rise);

			// Sleep stops the timebase, so only the wake mode is live then as an interrupt source.
			assign event_q = cpu_sleep ? (mode_wake & rise) : event_awake;

			////////////////////////////////////////////////////////////////////////
			// Buffer control.
			wire logic stores;
			wire logic [DATA_W-1:0] tstamp;
			wire logic full;
			wire logic empty;
			wire logic do_rd;
			wire logic blocked;
			wire logic do_wr;
			wire logic ovf_set;
			wire logic [2:0] level_nxt;
			wire logic [2:0] wr_idx;

			// The wake mode is an interrupt source only and never fills the buffer.
			assign stores = event_q & ~cpu_sleep & ~mode_wake;
			assign tstamp = ctrl_r.timebase_select ? timer3_count : timer2_count;
			assign full = (level_r == 3'(`ICC_DEPTH));
			assign empty = (level_r == 3'h0);

			// A read of an empty buffer is ignored, so the level can never wrap below zero.
			assign do_rd = buf_rd[g] & ~empty;

			// Overflow blocks storing until the buffer is fully drained.
			assign blocked = ovf_r & ~empty;

			// A read in the same cycle frees a slot, so a capture on a full buffer then still lands unless overflow is already set.
			assign do_wr = stores & ~blocked & (~full | do_rd);
			assign ovf_set = stores & full & ~do_rd & ~mode_every;
			assign level_nxt = 3'(level_r + 3'(do_wr) - 3'(do_rd));
			assign wr_idx = 3'(level_r - 3'(do_rd));

			////////////////////////////////////////////////////////////////////////
			// Interrupt and wake-up decode.
			wire logic ev_done;
			wire logic count_bypass;
			wire logic irq_set;
			wire logic run_ok;
			wire logic wake_set;

			assign ev_done = (ev_cnt_r == ctrl_r.irq_event_count_sel);

			// These cases flag every event and ignore the event count setting.
			assign count_bypass = mode_every | mode_wake | cpu_sleep;
			assign irq_set = event_q & (count_bypass | ev_done);

			// Stop-in-idle freezes the prescaler and the event count and keeps the interrupt flag from setting while the processor idles.
			assign run_ok = ~(cpu_idle & ctrl_r.stop_in_idle_bit);
			assign wake_set = (cpu_sleep | cpu_idle) & mode_wake & capture_irq_enable[g] & rise;

			////////////////////////////////////////////////////////////////////////
			// Control register.
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					ctrl_r <= icc_ctrl_t'(`ICC_CTRL_RESET);
					ctrl_r.timebase_select <= `ICC_TB_RESET;
				end else if (ctrl_wr[g]) begin
					ctrl_r <= capture_control_reg[g];
				end
			end

			////////////////////////////////////////////////////////////////////////
			// Pin synchroniser; only the second flop feeds the edge detector.
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					sync1_r <= 1'b0;
					sync2_r <= 1'b0;
					prev_r <= 1'b0;
				end else begin
					sync1_r <= cap_pin[g];
					sync2_r <= sync1_r;
					prev_r <= sync2_r;
				end
			end

			////////////////////////////////////////////////////////////////////////
			// Prescaler edge counter.
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					pre_cnt_r <= 4'h0;
				end else if (mode_off || !is_pre) begin
					pre_cnt_r <= 4'h0;
				end else if (rise && run_ok) begin
					pre_cnt_r <= pre_hit ? 4'h0 : 4'(pre_cnt_r + 4'h1);
				end
			end

			////////////////////////////////////////////////////////////////////////
			// Fill level, status flags and read data.
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					level_r <= 3'h0;
					ovf_r <= 1'b0;
					bne_r <= 1'b0;
					rdata_r <= '0;
				end else begin
					level_r <= level_nxt;
					bne_r <= (level_nxt != 3'h0);
					if (ovf_set) begin
						ovf_r <= 1'b1;
					end else if (level_nxt == 3'h0) begin
						ovf_r <= 1'b0;
					end
					if (do_rd) begin
						rdata_r <= fifo_r[0];
					end
				end
			end

			////////////////////////////////////////////////////////////////////////
			// Shift register keeps the oldest entry at slot 0; undefined-read case just repeats the last popped word.
			// The words carry no reset, since the fill level alone says which of them are valid.
			always_ff @(posedge sys_clk) begin
				for (int i = 0; i < `ICC_DEPTH; i++) begin
					if (do_wr && (wr_idx == 3'(i))) begin
						fifo_r[i] <= tstamp;
					end else if (do_rd && (i < `ICC_DEPTH - 1)) begin
						fifo_r[i] <= fifo_r[i + 1];
					end
				end
			end

			////////////////////////////////////////////////////////////////////////
			// Event counter, interrupt flag and wake request.
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					ev_cnt_r <= 2'h0;
					irq_r <= 1'b0;
					wake_r <= 1'b0;
				end else begin
					if (mode_off) begin
						ev_cnt_r <= 2'h0;
					end else if (event_q && run_ok) begin
						ev_cnt_r <= ev_done ? 2'h0 : 2'(ev_cnt_r + 2'h1);
					end
					// Set beats a simultaneous clear so no event is lost.
					if (irq_set && run_ok) begin
						irq_r <= 1'b1;
					end else if (irq_flag_clr[g]) begin
						irq_r <= 1'b0;
					end
					// Wake-up does not depend on the timer running, only on the pin edge.
					wake_r <= wake_set;
				end
			end

			////////////////////////////////////////////////////////////////////////
			// Outputs, each taken straight from a flop.
			assign buf_rdata[g] = rdata_r;
			assign chan_status[g] = '{
				buffer_not_empty_flag: bne_r,
				capture_overflow_flag: ovf_r,
				capture_irq_flag: irq_r,
				wake_req: wake_r
			};
			assign wake_vec[g] = wake_r;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Shared wake-up output; registered so that it comes straight from a flop.
	// It trails the per-channel wake request by one cycle.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_up <= 1'b0;
		end else begin
			wake_up <= |wake_vec;
		end
	end
endmodule

// File: tb/icc_capture_props.sv
// Purpose: Assertions on channel 0 of the capture block.
// Assumes: Bound from the bench top.
// Notes: All channels share one logic.
`timescale 1ns/1ps
`include "icc_defs.svh"
module icc_capture_props #(
	parameter int NUM_CH = 8,
	parameter int DATA_W = 16
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [NUM_CH-1:0] cap_pin,
	input wire icc_pkg::icc_ctrl_t [NUM_CH-1:0] capture_control_reg,
	input wire logic [NUM_CH-1:0] ctrl_wr,
	input wire logic [NUM_CH-1:0] buf_rd,
	input wire logic [NUM_CH-1:0][DATA_W-1:0] buf_rdata,
	input wire icc_pkg::icc_stat_t [NUM_CH-1:0] chan_status,
	input wire logic wake_up
);
	import icc_pkg::*;
	logic [2:0] mode_r;
	wire logic ne = chan_status[0].buffer_not_empty_flag;
	wire logic ov = chan_status[0].capture_overflow_flag;
	wire logic wq = chan_status[0].wake_req;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			mode_r <= `ICC_MODE_OFF;
		else if (ctrl_wr[0])
			mode_r <= capture_control_reg[0].capture_mode_sel;
	end
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_flag_soon;
		##[1:6] chan_status[0].capture_irq_flag;
	endsequence
	a_every_irq: assert property ($changed(cap_pin[0]) && mode_r == `ICC_MODE_EVERY |-> s_flag_soon)
		else $error("no flag");
	a_every_no_ovf: assert property (mode_r == `ICC_MODE_EVERY |-> !$rose(ov))
		else $error("overflow");
	a_ovf_held: assert property (ov |-> ne)
		else $error("overflow empty");
	a_ne_by_read: assert property ($fell(ne) |-> $past(buf_rd[0]) || $past(buf_rd[0], 2))
		else $error("empty unread");
	a_rdata_held: assert property (!$past(buf_rd[0]) && !$past(buf_rd[0], 2) |-> $stable(buf_rdata[0]))
		else $error("data moved");
	a_wake_mode: assert property (wq |-> mode_r == `ICC_MODE_WAKE)
		else $error("wake mode");
	a_wake_follow: assert property (wq |=> wake_up)
		else $error("no wake");
	a_wake_pulse: assert property (wake_up |=> !wake_up)
		else $error("long wake");
endmodule

// File: tb/icc_timebase.sv
// Purpose: Two timebase counters held at a seed.
// Assumes: The bench sets the seed.
// Notes: Timer3 shows the complement.
`timescale 1ns/1ps
module icc_timebase (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [15:0] tmr_seed,
	output logic [15:0] timer2_count,
	output logic [15:0] timer3_count
);
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer2_count <= 16'h0000;
			timer3_count <= 16'hffff;
		end else begin
			timer2_count <= tmr_seed;
			timer3_count <= ~tmr_seed;
		end
	end
endmodule

// File: tb/icc_capture_tb_top.sv
// Purpose: Bench for channel 0.
// Assumes: Timers stand still.
// Notes: Status nibble is ne, ov, irq, wake.
`timescale 1ns/1ps
`include "icc_defs.svh"
module icc_capture_tb_top;
	import icc_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic slp = 1'b0;
	logic idl = 1'b0;
	logic wk;
	logic [7:0] pin = 8'h00, wr = 8'h00, ie = 8'h00, rd = 8'h00, clr = 8'h00;
	logic [15:0] seed = 16'h0000, t2, t3;
	logic [7:0][15:0] rdat;
	icc_ctrl_t [7:0] ctrl = 56'h0;
	icc_stat_t [7:0] st;
	int err_count = 0, checks = 0, cyc = 0, n;
	always #5 sys_clk = ~sys_clk;
	icc_timebase u_icc_timebase (.sys_clk(sys_clk), .sys_rst(sys_rst), .tmr_seed(seed), .timer2_count(t2),
		.timer3_count(t3));
	icc_capture u_icc_capture (.sys_clk(sys_clk), .sys_rst(sys_rst), .cap_pin(pin), .timer2_count(t2),
		.timer3_count(t3), .cpu_sleep(slp), .cpu_idle(idl), .capture_control_reg(ctrl), .ctrl_wr(wr),
		.capture_irq_enable(ie), .buf_rd(rd), .irq_flag_clr(clr), .buf_rdata(rdat), .chan_status(st), .wake_up(wk));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 5000) begin
			err_count++;
			close_out();
		end
	end
	// Each write also clears the interrupt flag; words left in the buffer carry over to the next scenario.
	task automatic cfg(input logic [2:0] m, input logic [1:0] s, input logic tb);
		ctrl[0] = '{1'b0, tb, s, m};
		wr[0] = 1'b1;
		clr[0] = 1'b1;
		@(negedge sys_clk);
		wr[0] = 1'b0;
		clr[0] = 1'b0;
	endtask
	task automatic tog(input int k);
		repeat (k) begin
			pin[0] = ~pin[0];
			repeat (5) @(negedge sys_clk);
		end
	endtask
	task automatic pop(input logic [15:0] exp);
		rd[0] = 1'b1;
		@(negedge sys_clk);
		rd[0] = 1'b0;
		@(negedge sys_clk);
		chk(rdat[0], exp);
	endtask
	initial begin
		repeat (6) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk({11'h000, wk, st[0]}, 16'h0000);
		cfg(`ICC_MODE_RISE, 2'h0, 1'b0);
		for (n = 0; n < 6; n++) begin
			seed = 16'h1230 + 16'(n);
			tog(2);
		end
		chk(16'(st[0]), 16'h000e);
		for (n = 0; n < 4; n++)
			pop(16'h1230 + 16'(n));
		chk(16'(st[0]), 16'h0002);
		cfg(`ICC_MODE_FALL, 2'h0, 1'b1);
		seed = 16'h5a5a;
		tog(2);
		pop(16'ha5a5);
		cfg(`ICC_MODE_PRE4, 2'h0, 1'b0);
		tog(4);
		for (n = 3; n < 16; n += 12) begin
			cfg(`ICC_MODE_OFF, 2'h0, 1'b0);
			cfg(n == 3 ? `ICC_MODE_PRE4 : `ICC_MODE_PRE16, 2'h0, 1'b0);
			tog(2 * n);
			chk(16'(st[0]), 16'h0000);
			tog(2);
			pop(seed);
		end
		cfg(`ICC_MODE_RISE, 2'h1, 1'b0);
		tog(2);
		chk(16'(st[0]), 16'h0008);
		tog(2);
		chk(16'(st[0]), 16'h000a);
		cfg(`ICC_MODE_EVERY, 2'h3, 1'b0);
		tog(6);
		chk(16'(st[0]), 16'h000a);
		// Only the four stored words are read; a read of an empty buffer has no defined value.
		repeat (4) pop(seed);
		chk(16'(st[0]), 16'h0002);
		chk(rdat[0], seed);
		cfg(`ICC_MODE_WAKE, 2'h0, 1'b0);
		ie[0] = 1'b1;
		slp = 1'b1;
		pin[0] = 1'b1;
		n = 0;
		repeat (8) begin
			@(negedge sys_clk);
			n += int'(wk === 1'b1);
		end
		chk(16'(n), 16'h0001);
		chk(16'(st[0]), 16'h0002);
		slp = 1'b0;
		pin[0] = 1'b0;
		repeat (5) @(negedge sys_clk);
		idl = 1'b1;
		pin[0] = 1'b1;
		n = 0;
		repeat (8) begin
			@(negedge sys_clk);
			n += int'(wk === 1'b1);
		end
		chk(16'(n), 16'h0001);
		chk({st[4], st[3], st[2], st[1]}, 16'h0000);
		chk({4'h0, st[7], st[6], st[5]}, 16'h0000);
		close_out();
	end
endmodule
bind icc_capture icc_capture_props #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) u_icc_capture_props (.sys_clk(sys_clk),
	.sys_rst(sys_rst), .cap_pin(cap_pin), .capture_control_reg(capture_control_reg), .ctrl_wr(ctrl_wr),
	.buf_rd(buf_rd), .buf_rdata(buf_rdata), .chan_status(chan_status), .wake_up(wake_up));
